// ===== rtl/peripheral_bus_bridge.v
// Main bus to peripheral bus bridge with access cycle timing.
// Assumes requests, divisors and ratio mode come from the core clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "bridge_consts.vh"

// Overview of operation
// R1 - Access equals main, sync, peripheral cycles
// R2 - Peripheral cycle count chosen per target register
// R3 - Sync for buses two to six, not errors
// R4 - Main plus sync within one peripheral tick; the code allows up to one tick plus one core cycle
// R5 - Slow core counts core cycles, next follows
// R6 - External controller syncs to external bus tick
// R7 - Counts hold only without bus contention
// R8 - Software reads back last written register only
// R9 - Masters avoid reserved regions of map
// R10 - Decode program and data memory ranges
// R11 - Timer registers two/three ticks, two core; the code uses one tick, or one core cycle in slow core mode
// R12 - Timer shared registers accept 8/16 bit
// R13 - Serial registers accept only 8-bit accesses
// R14 - Stall requester until peripheral access completes
module peripheral_bus_bridge #(
  parameter DIV_WIDTH = 4
) (
  input  wire                 i_mclk,
  input  wire                 i_rst_b,
  input  wire                 i_core_slow,
  input  wire [DIV_WIDTH-1:0] i_per_div,
  input  wire [DIV_WIDTH-1:0] i_ext_div,
  input  wire                 i_contend,
  input  wire                 i_req,
  input  wire [31:0]          i_addr,
  input  wire                 i_write,
  input  wire [1:0]           i_size,
  input  wire [31:0]          i_wdata,
  input  wire [31:0]          i_per_rdata,
  output reg                  o_busy,
  output reg                  o_ack,
  output reg                  o_err,
  output reg  [31:0]          o_rdata,
  output reg                  o_sel_prog,
  output reg                  o_sel_data,
  output reg                  o_per_req,
  output reg  [2:0]           o_per_bus,
  output reg  [31:0]          o_per_addr,
  output reg                  o_per_write,
  output reg  [1:0]           o_per_size,
  output reg  [31:0]          o_per_wdata
);
  localparam ST_IDLE = 3'h0;
  localparam ST_MAIN = 3'h1;
  localparam ST_SYNC = 3'h2;
  localparam ST_PERI = 3'h3;
  localparam ST_DONE = 3'h4;

  reg [2:0] state;
  reg [2:0] cls;
  reg [3:0] cnt;
  reg [2:0] next_cls;
  reg       next_err;
  wire      per_tick;
  wire      ext_tick;
  wire      hit_prog;
  wire      hit_data;
  wire      hit_tmr;
  wire      hit_cmn;
  wire      hit_sci;
  wire      hit_ext;
  wire      hit_berr;
  wire      sync_tick;
  wire      core_paced;

  clock_tick_divider #(.WIDTH(DIV_WIDTH)) u_per_div (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_div   (i_per_div),
    .o_tick  (per_tick)
  );

  clock_tick_divider #(.WIDTH(DIV_WIDTH)) u_ext_div (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_div   (i_ext_div),
    .o_tick  (ext_tick)
  );

  // Address window hits; only the shared timer window overlaps (it lies inside the timer window), so priority below is only for safety
  assign hit_prog   = (i_addr >= `PROG_BASE);
  assign hit_data   = (i_addr <= `DATA_LIMIT);
  assign hit_tmr    = (i_addr >= `TMR_BASE) && (i_addr <= `TMR_LIMIT);
  assign hit_cmn    = (i_addr >= `TMR_CMN_BASE) && (i_addr <= `TMR_CMN_LIMIT);
  assign hit_sci    = (i_addr >= `SCI_BASE) && (i_addr <= `SCI_LIMIT);
  assign hit_ext    = (i_addr >= `EXT_BASE) && (i_addr <= `EXT_LIMIT);
  assign hit_berr   = (i_addr >= `BERR_BASE) && (i_addr <= `BERR_LIMIT);
  assign sync_tick  = (cls == `CLS_EXT) ? ext_tick : per_tick;
  assign core_paced = (cls == `CLS_BERR) || (i_core_slow && (cls != `CLS_EXT));

  // Decode of the incoming address and size check
  always @* begin
    next_cls = `CLS_RSVD;
    next_err = 1'b0;
    if (hit_prog) begin
      next_cls = `CLS_PROG; // R10
    end else if (hit_data) begin
      next_cls = `CLS_DATA; // R10
    end else if (hit_tmr) begin
      next_cls = `CLS_TMR;
    end else if (hit_sci) begin
      next_cls = `CLS_SCI;
    end else if (hit_ext) begin
      next_cls = `CLS_EXT;
    end else if (hit_berr) begin
      next_cls = `CLS_BERR;
    end
    if (next_cls == `CLS_RSVD) begin
      next_err = 1'b1; // R9
    end
    if (next_cls == `CLS_TMR && hit_cmn) begin
      next_err = (i_size != `SIZE_8) && (i_size != `SIZE_16); // R12
    end
    if (next_cls == `CLS_SCI) begin
      next_err = (i_size != `SIZE_8); // R13
    end
  end

  // Reserved and wrongly sized accesses end after one cycle with no target strobe
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state       <= ST_IDLE;
      cls         <= `CLS_RSVD;
      cnt         <= 4'h0;
      o_busy      <= 1'b0;
      o_ack       <= 1'b0;
      o_err       <= 1'b0;
      o_rdata     <= 32'h00000000;
      o_sel_prog  <= 1'b0;
      o_sel_data  <= 1'b0;
      o_per_req   <= 1'b0;
      o_per_bus   <= `BUS_MAIN;
      o_per_addr  <= 32'h00000000;
      o_per_write <= 1'b0;
      o_per_size  <= `SIZE_8;
      o_per_wdata <= 32'h00000000;
    end else begin
      o_ack <= 1'b0;
      case (state)
        ST_IDLE: begin
          // A contended cycle is not taken, so quoted counts stay exact
          if (i_req && !i_contend) begin // R7
            cls         <= next_cls;
            o_busy      <= 1'b1; // R14
            o_err       <= next_err;
            o_per_addr  <= i_addr;
            o_per_write <= i_write;
            o_per_size  <= i_size;
            o_per_wdata <= i_wdata;
            state       <= next_err ? ST_DONE : ST_MAIN;
          end
        end
        ST_MAIN: begin
          // One main bus cycle precedes every target phase
          o_sel_prog <= (cls == `CLS_PROG); // R10
          o_sel_data <= (cls == `CLS_DATA); // R10
          case (cls)
            `CLS_TMR: o_per_bus <= `BUS_TMR;
            `CLS_SCI: o_per_bus <= `BUS_SCI;
            `CLS_EXT: o_per_bus <= `BUS_EXT;
            `CLS_BERR: o_per_bus <= `BUS_ONE;
            default: o_per_bus <= `BUS_MAIN;
          endcase
          if (cls == `CLS_PROG || cls == `CLS_DATA) begin
            state <= ST_DONE; // R1
          end else if (cls == `CLS_BERR) begin
            cnt       <= `BERR_PBUS_CYC; // R3
            o_per_req <= 1'b1;
            state     <= ST_PERI;
          end else if (i_core_slow && cls != `CLS_EXT) begin
            cnt       <= `CORE_SLOW_CYC; // R5
            o_per_req <= 1'b1;
            state     <= ST_PERI;
          end else begin
            state <= ST_SYNC; // R3
          end
        end
        ST_SYNC: begin
          // Wait for the divided clock edge; never longer than one tick period
          if (sync_tick) begin // R4 R6
            o_per_req <= 1'b1;
            state     <= ST_PERI;
            case (cls)
              `CLS_TMR: cnt <= `TMR_PBUS_TICKS; // R2 R11
              `CLS_SCI: cnt <= `SCI_PBUS_TICKS; // R2 R13
              default: cnt <= `EXT_PBUS_TICKS; // R2 R6
            endcase
          end
        end
        ST_PERI: begin
          // Core cycles count in slow core mode except for external accesses, and for bus error registers
          if (core_paced || sync_tick) begin // R1 R5 R11
            if (cnt == 4'h1) begin
              o_rdata   <= o_per_write ? 32'h00000000 : i_per_rdata;
              o_per_req <= 1'b0;
              state     <= ST_DONE;
            end else begin
              cnt <= cnt - 4'h1;
            end
          end
        end
        ST_DONE: begin
          // Release the stall; the next request is taken in the following cycle
          o_ack      <= 1'b1; // R14
          o_busy     <= 1'b0; // R5
          o_sel_prog <= 1'b0;
          o_sel_data <= 1'b0;
          o_per_bus  <= `BUS_MAIN;
          state      <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // peripheral_bus_bridge
`default_nettype wire

// ===== shared/bridge_consts.vh
// Constants for the peripheral bus access timing bridge.
// Assumes inclusion by its bare name from the design files.
`ifndef BRIDGE_CONSTS_VH
`define BRIDGE_CONSTS_VH

// Address map
`define PROG_BASE        32'hffff0000
`define DATA_LIMIT       32'h00002fff
`define TMR_BASE         32'h00088600
`define TMR_LIMIT        32'h000888ff
`define TMR_CMN_BASE     32'h00088660
`define TMR_CMN_LIMIT    32'h00088695
`define SCI_BASE         32'h0008a000
`define SCI_LIMIT        32'h0008a0ff
`define EXT_BASE         32'h00081300
`define EXT_LIMIT        32'h000813ff
`define BERR_BASE        32'h00081400
`define BERR_LIMIT       32'h000814ff

// Access sizes
`define SIZE_8           2'h0
`define SIZE_16          2'h1
`define SIZE_32          2'h2

// Target classes
`define CLS_PROG         3'h0
`define CLS_DATA         3'h1
`define CLS_TMR          3'h2
`define CLS_SCI          3'h3
`define CLS_EXT          3'h4
`define CLS_BERR         3'h5
`define CLS_RSVD         3'h6

// Peripheral bus numbers
`define BUS_MAIN         3'h0
`define BUS_ONE          3'h1
`define BUS_TMR          3'h3
`define BUS_SCI          3'h2
`define BUS_EXT          3'h6

// Cycle counts after the main bus phase, and after the synchronisation phase for ticked timer, serial and external accesses
`define TMR_PBUS_TICKS   4'h1
`define SCI_PBUS_TICKS   4'h1
`define EXT_PBUS_TICKS   4'h2
`define BERR_PBUS_CYC    4'h2
`define CORE_SLOW_CYC    4'h1

`endif

// ===== rtl/clock_tick_divider.v
// Divided clock tick generator.
// Assumes a static divisor from the core clock domain; zero acts as one.
`timescale 1ns/100ps
`default_nettype none
module clock_tick_divider #(
  parameter WIDTH = 4
) (
  input  wire             i_mclk,
  input  wire             i_rst_b,
  input  wire [WIDTH-1:0] i_div,
  output reg              o_tick
);
  reg [WIDTH-1:0] count;
  wire            last = (count + {{(WIDTH-1){1'b0}}, 1'b1} >= i_div);

  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      count  <= {WIDTH{1'b0}};
      o_tick <= 1'b0;
    end else begin
      o_tick <= last;
      if (last) begin
        count <= {WIDTH{1'b0}};
      end else begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // clock_tick_divider
`default_nettype wire

// ===== bench/bridge_peer.sv
// Peripheral side model: answers reads with the inverted address.
// Assumes the bridge samples read data only while its peripheral phase is active.
`timescale 1ns/100ps
`default_nettype none
module bridge_peer (
  input  wire logic        i_mclk,
  input  wire logic        i_per_req,
  input  wire logic [31:0] i_per_addr,
  output logic      [31:0] o_rdata
);
  logic [31:0] junk = 32'h5a5a5a5a;
  // Outside the phase the data keeps changing so stale captures show up
  always @(posedge i_mclk) junk <= ~junk + 32'h1;
  assign o_rdata = i_per_req ? ~i_per_addr : junk;
endmodule // bridge_peer
`default_nettype wire

// ===== bench/peripheral_bus_bridge_sva.sv
// Timing checker for the bridge, bound to its ports.
// Assumes divisors of at most 4 in the bench.
`timescale 1ns/100ps
`default_nettype none
module bridge_sva (
  input wire logic        i_mclk,
  input wire logic        i_rst_b,
  input wire logic        i_core_slow,
  input wire logic        i_contend,
  input wire logic        i_req,
  input wire logic [31:0] i_addr,
  input wire logic [1:0]  i_size,
  input wire logic        o_busy,
  input wire logic        o_ack,
  input wire logic        o_err,
  input wire logic        o_sel_prog,
  input wire logic        o_sel_data,
  input wire logic [2:0]  o_per_bus
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  wire tk = i_req && !i_contend && !o_busy && !o_ack;
  wire tmr = i_addr >= 32'h00088700 && i_addr <= 32'h000888ff;
  property p_stall; tk |=> o_busy; endproperty
  a_stall: assert property (p_stall) else $error("busy not raised");
  property p_hold; o_busy |=> o_busy || o_ack; endproperty
  a_hold: assert property (p_hold) else $error("busy dropped early");
  property p_prog; tk && i_addr >= 32'hffff0000 |-> ##2 o_sel_prog ##1 o_ack; endproperty
  a_prog: assert property (p_prog) else $error("program decode");
  property p_data; tk && i_addr <= 32'h00002fff |-> ##2 o_sel_data ##1 o_ack; endproperty
  a_data: assert property (p_data) else $error("data decode");
  property p_berr; tk && i_addr[31:8] == 24'h000814 |-> ##2 o_per_bus == 3'h1 ##3 o_ack;
  endproperty
  a_berr: assert property (p_berr) else $error("bus error regs timing");
  property p_cont; i_contend && !o_busy && !o_ack |=> !o_busy; endproperty
  a_cont: assert property (p_cont) else $error("contended take");
  property p_size; tk && i_addr[31:8] == 24'h0008a0 && i_size != 2'h0 |=> o_err ##1 o_ack;
  endproperty
  a_size: assert property (p_size) else $error("serial size");
  property p_cmn; tk && i_addr[31:8] == 24'h000886 && i_size == 2'h1 |=> !o_err; endproperty
  a_cmn: assert property (p_cmn) else $error("shared timer 16 bit");
  property p_slow; tk && tmr && i_core_slow |-> ##4 o_ack; endproperty
  a_slow: assert property (p_slow) else $error("slow core timing");
  property p_fast; tk && tmr && !i_core_slow |-> ##[3:12] o_ack; endproperty
  a_fast: assert property (p_fast) else $error("timer timing");
endmodule // bridge_sva
bind peripheral_bus_bridge bridge_sva u_sva (.i_mclk, .i_rst_b, .i_core_slow, .i_contend,
  .i_req, .i_addr, .i_size, .o_busy, .o_ack, .o_err, .o_sel_prog, .o_sel_data, .o_per_bus);
`default_nettype wire

// ===== bench/peripheral_bus_bridge_test.sv
// Self-checking bench for the bridge access timing.
// Assumes the peer model answers reads with the inverted address.
`timescale 1ns/100ps
`default_nettype none
module peripheral_bus_bridge_test;
  logic i_mclk = 0, i_rst_b = 0, slow = 0, cont = 0, req = 0, wr = 0;
  logic [3:0] pdiv = 4'h2, xdiv = 4'h2;
  logic [31:0] addr = 32'h0, prd;
  logic [1:0] size = 2'h0;
  logic o_busy, o_ack, o_err;
  logic [31:0] o_rdata;
  logic o_per_req, o_per_write;
  logic [1:0] o_per_size;
  logic [31:0] o_per_addr, o_per_wdata;
  int errors = 0, checked = 0;
  peripheral_bus_bridge dut_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_core_slow(slow),
    .i_per_div(pdiv), .i_ext_div(xdiv), .i_contend(cont), .i_req(req), .i_addr(addr),
    .i_write(wr), .i_size(size), .i_wdata(~addr), .i_per_rdata(prd), .o_busy(o_busy),
    .o_ack(o_ack), .o_err(o_err), .o_rdata(o_rdata), .o_sel_prog(), .o_sel_data(),
    .o_per_req(o_per_req), .o_per_bus(), .o_per_addr(o_per_addr),
    .o_per_write(o_per_write), .o_per_size(o_per_size), .o_per_wdata(o_per_wdata));
  bridge_peer peer_u (.i_mclk(i_mclk), .i_per_req(o_per_req), .i_per_addr(o_per_addr),
    .o_rdata(prd));
  initial forever #4 i_mclk = ~i_mclk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One access; c contended cycles first, ack expected lo..hi cycles after take
  task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] s,
                     input int lo, input int hi, input logic e, input int c);
    int n;
    @(posedge i_mclk); #1;
    req = 1; addr = a; wr = w; size = s; cont = (c > 0);
    if (c > 0) begin
      repeat (c) @(posedge i_mclk);
      #1;
      chk("busy", 0, o_busy);
      cont = 0;
    end
    @(posedge i_mclk); #1;
    chk("busy", 1, o_busy);
    n = 1;
    while (o_ack !== 1'b1 && n < 40) begin
      @(posedge i_mclk); #1;
      n++;
    end
    req = 0;
    chk("cycles", (n >= lo && n <= hi) ? n : lo, n);
    chk("err", e, o_err);
    chk("per_addr", a, o_per_addr);
    chk("per_wdata", ~a, o_per_wdata);
    chk("per_ctl", {w, s}, {o_per_write, o_per_size});
    if (!w && !e && a[31:16] == 16'h0008) chk("rdata", ~a, o_rdata);
  endtask
  task automatic t_mem;
    acc(32'hffff0000, 0, 2'h2, 3, 3, 0, 0);
    acc(32'h00002fff, 1, 2'h0, 3, 3, 0, 0);
    acc(32'h00003000, 0, 2'h0, 2, 2, 1, 0);
    $display("mem done");
  endtask
  task automatic t_berr;
    acc(32'h00081404, 0, 2'h2, 5, 5, 0, 3);
    $display("berr done");
  endtask
  task automatic t_fast;
    for (int d = 2; d <= 4; d++) begin
      pdiv = 4'(d);
      acc(32'h00088700, 0, 2'h0, d + 4, 2 * d + 3, 0, 0);
      acc(32'h0008a064, 0, 2'h0, d + 4, 2 * d + 3, 0, 0);
    end
    $display("fast done");
  endtask
  task automatic t_slow;
    slow = 1;
    acc(32'h00088706, 1, 2'h1, 4, 4, 0, 0);
    acc(32'h0008a0cc, 0, 2'h0, 4, 4, 0, 0);
    slow = 0;
    $display("slow done");
  endtask
  task automatic t_size;
    acc(32'h0008a065, 0, 2'h1, 2, 2, 1, 0);
    acc(32'h00088680, 0, 2'h2, 2, 2, 1, 0);
    acc(32'h00088690, 0, 2'h1, 8, 11, 0, 0);
    $display("size done");
  endtask
  // Two writes, then only the last one is read back before going on
  task automatic t_back;
    acc(32'h0008a0c2, 1, 2'h0, 8, 11, 0, 0);
    acc(32'h0008a0c3, 1, 2'h0, 8, 11, 0, 0);
    acc(32'h0008a0c3, 0, 2'h0, 8, 11, 0, 0);
    $display("readback done");
  endtask
  task automatic t_ext;
    xdiv = 4'h3;
    acc(32'h00081310, 0, 2'h2, 10, 12, 0, 2);
    $display("ext done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge i_mclk);
    #1 i_rst_b = 1;
    t_mem();
    t_berr();
    t_fast();
    t_slow();
    t_size();
    t_back();
    t_ext();
    complete_run();
  end
endmodule // peripheral_bus_bridge_test
`default_nettype wire
